//--- hw/pit_consts.vh
// register offsets, field layouts and reset values of the interval timer
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH
`define PIT_ADDR_W        4
`define PIT_OFS_COUNT     4'h0
`define PIT_OFS_SCALE     4'h1
`define PIT_OFS_PERIOD    4'h2
`define PIT_OFS_CTRL      4'h3
`define PIT_OFS_STATUS    4'h4
`define PIT_OFS_MASK      4'h5
`define PIT_OFS_PRECNT    4'h6
`define PIT_CTRL_EN_BIT   0
`define PIT_STAT_ZERO_BIT 0
`define PIT_RST_COUNT     16'h0000
`define PIT_RST_SCALE     8'h00
`define PIT_RST_PERIOD    16'h0000
`define PIT_RST_CTRL      1'b0
`define PIT_RST_MASK      1'b0
`define PIT_RST_STAT      1'b0
`define PIT_RST_PULSE     1'b0
`define PIT_RST_RDATA     16'h0000
`endif

//--- hw/pit_timer.v
// prescaled 16-bit interval timer with register port and interrupt
`timescale 1ns/1ps
`include "pit_consts.vh"

module pit_timer #(
  parameter CNT_W   = 16,
  parameter SCALE_W = 8
) (
  // clock and reset
  input  wire                   mclk,
  input  wire                   rst_n,
  // register port
  input  wire [`PIT_ADDR_W-1:0] reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [15:0]            reg_rdata,
  // interrupt and event
  output wire                   timer_irq,
  output reg                    timer_zero_pulse
);

  // ==========================================================
  // helper functions

  // strobe qualified by a register index
  function hit;
    input                   strobe;
    input [`PIT_ADDR_W-1:0] addr;
    input [`PIT_ADDR_W-1:0] ofs;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  // count minus one
  function [CNT_W-1:0] cnt_dec;
    input [CNT_W-1:0] val;
    begin
      cnt_dec = val - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // prescaler minus one
  function [SCALE_W-1:0] pre_dec;
    input [SCALE_W-1:0] val;
    begin
      pre_dec = val - {{(SCALE_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // count-wide value in the low bits of a read word
  function [15:0] pad_cnt;
    input [CNT_W-1:0] val;
    begin
      pad_cnt            = 16'h0000;
      pad_cnt[CNT_W-1:0] = val;
    end
  endfunction

  // prescaler-wide value in the low bits of a read word
  function [15:0] pad_pre;
    input [SCALE_W-1:0] val;
    begin
      pad_pre              = 16'h0000;
      pad_pre[SCALE_W-1:0] = val;
    end
  endfunction

  // single flag in bit 0 of a read word
  function [15:0] pad_bit;
    input val;
    begin
      pad_bit    = 16'h0000;
      pad_bit[0] = val;
    end
  endfunction

  // ==========================================================
  // state and next values
  reg [CNT_W-1:0]   timer_count_value_r;
  reg [CNT_W-1:0]   timer_count_value_nxt;
  reg [SCALE_W-1:0] timer_prescale_value_r;
  reg [SCALE_W-1:0] timer_prescale_value_nxt;
  reg [CNT_W-1:0]   timer_reload_period_r;
  reg [CNT_W-1:0]   timer_reload_period_nxt;
  reg [SCALE_W-1:0] pre_cnt_r;
  reg [SCALE_W-1:0] pre_cnt_nxt;
  reg               enable_r;
  reg               enable_nxt;
  reg               zero_stat_r;
  reg               zero_stat_nxt;
  reg               zero_mask_r;
  reg               zero_mask_nxt;
  reg [15:0]        rdata_nxt;

  // ==========================================================
  // register decode
  wire wr_count  = hit(reg_wr, reg_addr, `PIT_OFS_COUNT);
  wire wr_scale  = hit(reg_wr, reg_addr, `PIT_OFS_SCALE);
  wire wr_period = hit(reg_wr, reg_addr, `PIT_OFS_PERIOD);
  wire wr_ctrl   = hit(reg_wr, reg_addr, `PIT_OFS_CTRL);
  wire wr_status = hit(reg_wr, reg_addr, `PIT_OFS_STATUS);
  wire wr_mask   = hit(reg_wr, reg_addr, `PIT_OFS_MASK);

  // ==========================================================
  // prescaler
  wire dec_strobe = enable_r && (pre_cnt_r == {SCALE_W{1'b0}});

  always @* begin
    pre_cnt_nxt = pre_cnt_r;
    if (wr_scale) begin
      // restart the period on a new scale value
      pre_cnt_nxt = reg_wdata[SCALE_W-1:0];
    end else if (!enable_r) begin
      // idle timer waits with a full period loaded
      pre_cnt_nxt = timer_prescale_value_r;
    end else if (dec_strobe) begin
      pre_cnt_nxt = timer_prescale_value_r;
    end else begin
      pre_cnt_nxt = pre_dec(pre_cnt_r);
    end
  end

  // ==========================================================
  // count, reload and zero event
  wire cnt_empty = (timer_count_value_r == {CNT_W{1'b0}});
  wire cnt_last  = (timer_count_value_r == {{(CNT_W-1){1'b0}}, 1'b1});
  // the step from one to zero is the zero event; reload replaces it
  wire zero_evt  = dec_strobe && cnt_last;

  always @* begin
    timer_count_value_nxt = timer_count_value_r;
    if (wr_count) begin
      // software write overrides a reload in the same cycle
      timer_count_value_nxt = reg_wdata[CNT_W-1:0];
    end else if (zero_evt) begin
      timer_count_value_nxt = timer_reload_period_r;
    end else if (dec_strobe && !cnt_empty) begin
      // a zero count stays put until it is written
      timer_count_value_nxt = cnt_dec(timer_count_value_r);
    end
  end

  // ==========================================================
  // control registers
  always @* begin
    timer_prescale_value_nxt = timer_prescale_value_r;
    timer_reload_period_nxt  = timer_reload_period_r;
    enable_nxt               = enable_r;
    zero_mask_nxt            = zero_mask_r;
    if (wr_scale)
      timer_prescale_value_nxt = reg_wdata[SCALE_W-1:0];
    if (wr_period)
      timer_reload_period_nxt = reg_wdata[CNT_W-1:0];
    if (wr_ctrl)
      enable_nxt = reg_wdata[`PIT_CTRL_EN_BIT];
    if (wr_mask)
      zero_mask_nxt = reg_wdata[`PIT_STAT_ZERO_BIT];
  end

  // ==========================================================
  // sticky status, set wins over write-one-to-clear
  always @* begin
    zero_stat_nxt = zero_stat_r;
    if (zero_evt)
      zero_stat_nxt = 1'b1;
    else if (wr_status && reg_wdata[`PIT_STAT_ZERO_BIT])
      zero_stat_nxt = 1'b0;
  end

  assign timer_irq = zero_stat_r & zero_mask_r;

  // ==========================================================
  // read port, data one cycle after the strobe
  always @* begin
    rdata_nxt = `PIT_RST_RDATA;
    if (reg_rd) begin
      case (reg_addr)
        `PIT_OFS_COUNT:  rdata_nxt = pad_cnt(timer_count_value_r);
        `PIT_OFS_SCALE:  rdata_nxt = pad_pre(timer_prescale_value_r);
        `PIT_OFS_PERIOD: rdata_nxt = pad_cnt(timer_reload_period_r);
        `PIT_OFS_CTRL:   rdata_nxt = pad_bit(enable_r);
        `PIT_OFS_STATUS: rdata_nxt = pad_bit(zero_stat_r);
        `PIT_OFS_MASK:   rdata_nxt = pad_bit(zero_mask_r);
        `PIT_OFS_PRECNT: rdata_nxt = pad_pre(pre_cnt_r);
        default:         rdata_nxt = `PIT_RST_RDATA;
      endcase
    end
  end

  // ==========================================================
  // state flip-flops
  always @(posedge mclk) begin
    if (!rst_n) begin
      timer_count_value_r    <= `PIT_RST_COUNT;
      timer_prescale_value_r <= `PIT_RST_SCALE;
      timer_reload_period_r  <= `PIT_RST_PERIOD;
      pre_cnt_r              <= `PIT_RST_SCALE;
      enable_r               <= `PIT_RST_CTRL;
      zero_stat_r            <= `PIT_RST_STAT;
      zero_mask_r            <= `PIT_RST_MASK;
      timer_zero_pulse       <= `PIT_RST_PULSE;
      reg_rdata              <= `PIT_RST_RDATA;
    end else begin
      timer_count_value_r    <= timer_count_value_nxt;
      timer_prescale_value_r <= timer_prescale_value_nxt;
      timer_reload_period_r  <= timer_reload_period_nxt;
      pre_cnt_r              <= pre_cnt_nxt;
      enable_r               <= enable_nxt;
      zero_stat_r            <= zero_stat_nxt;
      zero_mask_r            <= zero_mask_nxt;
      timer_zero_pulse       <= zero_evt;
      reg_rdata              <= rdata_nxt;
    end
  end

endmodule

//--- testbench/pit_timer_assertions.sv
// port assertions for the interval timer
`timescale 1ns/1ps
`include "pit_consts.vh"
module pit_chk (
  input wire logic        mclk, rst_n, reg_wr, reg_rd,
  input wire logic        timer_irq, timer_zero_pulse,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata
);
  wire rd_scale = reg_rd && reg_addr == `PIT_OFS_SCALE;
  wire rd_pre   = reg_rd && reg_addr == `PIT_OFS_PRECNT;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
  a_scale_narrow: assert property (
    $past(rd_scale) |-> reg_rdata[15:8] == 8'h00) else $error("scale wide");
  a_irq_rise: assert property (
    $rose(timer_irq) |-> timer_zero_pulse || $past(reg_wr))
    else $error("irq rose alone");
  a_irq_fall: assert property (
    $fell(timer_irq) && $past(rst_n) |-> $past(reg_wr))
    else $error("irq fell alone");
  a_pre_narrow: assert property (
    $past(rd_pre) |-> reg_rdata[15:8] == 8'h00) else $error("prescaler wide");
  cover property (timer_zero_pulse);
  cover property (timer_irq);
  cover property ($past(rd_scale));
endmodule
bind pit_timer pit_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .timer_irq(timer_irq), .timer_zero_pulse(timer_zero_pulse),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

//--- testbench/tb_pit_timer.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`include "pit_consts.vh"
module tb_pit_timer;
  logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic        timer_irq, timer_zero_pulse;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
  integer      seed = 85, bad_count = 0, checked = 0, i, n, s, p;
  always #50 mclk = ~mclk;
  pit_timer u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_irq(timer_irq),
    .timer_zero_pulse(timer_zero_pulse));
  function logic [15:0] gap(integer s, integer p);
    gap = 16'(p * (s + 1));
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1 rd = reg_rdata;
  endtask
  task wait_pulse(output integer c);
    c = 0;
    do begin
      @(posedge mclk);
      #1 c++;
    end while (timer_zero_pulse !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    for (i = 0; i < 8; i++) begin
      rdr(i[3:0]);
      chk(rd, 16'h0000);
    end
    $display("test reset done");
    wr(`PIT_OFS_SCALE, 16'hffff);
    rdr(`PIT_OFS_SCALE);
    chk(rd, 16'h00ff);
    $display("test scale width done");
    wr(`PIT_OFS_MASK, 16'h0001);
    for (i = 0; i < 7; i++) begin
      s = i == 0 ? 0 : $random(seed) & 7;
      p = i == 0 ? 1 : ($random(seed) & 15) + 1;
      if (i == 6) wr(`PIT_OFS_MASK, 16'h0000);
      wr(`PIT_OFS_SCALE, s[15:0]);
      wr(`PIT_OFS_PERIOD, p[15:0]);
      wr(`PIT_OFS_COUNT, p[15:0]);
      wr(`PIT_OFS_CTRL, 16'h0001);
      wait_pulse(n);
      wait_pulse(n);
      chk(n[15:0], gap(s, p));
      chk(16'(timer_irq), i == 6 ? 16'h0000 : 16'h0001);
      wr(`PIT_OFS_CTRL, 16'h0000);
      wr(`PIT_OFS_STATUS, 16'h0001);
      #1 chk(16'(timer_irq), 16'h0000);
      $display("test %0d done", i);
    end
    // scale 3: strobes at edges 4, 8, 12, 16 after enable
    wr(`PIT_OFS_SCALE, 16'h0003);
    wr(`PIT_OFS_PERIOD, 16'h0100);
    wr(`PIT_OFS_COUNT, 16'h0010);
    wr(`PIT_OFS_CTRL, 16'h0001);
    repeat (17) @(posedge mclk);
    rdr(`PIT_OFS_COUNT);
    chk(rd, 16'h000c);
    wr(`PIT_OFS_CTRL, 16'h0000);
    rdr(`PIT_OFS_PRECNT);
    chk(rd, 16'h0003);
    rdr(`PIT_OFS_PERIOD);
    chk(rd, 16'h0100);
    // a zero count must neither decrement nor raise an event
    wr(`PIT_OFS_COUNT, 16'h0000);
    wr(`PIT_OFS_CTRL, 16'h0001);
    repeat (20) @(posedge mclk);
    rdr(`PIT_OFS_COUNT);
    chk(rd, 16'h0000);
    rdr(`PIT_OFS_STATUS);
    chk(rd, 16'h0000);
    $display("test directed done");
    summarize();
  end
endmodule
